// ---- common/rsp_consts.svh ----
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

// word and field widths
`define RSP_ADDR_W 11
`define RSP_DATA_W 9
`define RSP_CHAIN_W 34
`define RSP_OUT_W 10

// chain positions, counted from the serial input end
`define RSP_POS_Q0 0
`define RSP_POS_FLT 9
`define RSP_POS_APAR 10
`define RSP_POS_A2 11
`define RSP_POS_A1 12
`define RSP_POS_A0 13
`define RSP_POS_A6 14
`define RSP_POS_A5 15
`define RSP_POS_A4 16
`define RSP_POS_A3 17
`define RSP_POS_A10 18
`define RSP_POS_A9 19
`define RSP_POS_A8 20
`define RSP_POS_A7 21
`define RSP_POS_WE 22
`define RSP_POS_CS 23
`define RSP_POS_CKE 24
`define RSP_POS_D0 25
`define RSP_POS_LAST 33

// output-side pattern loaded into the chain, bit 0 is the first data bit
`define RSP_SIGNATURE 10'h1a9

// reset values
`define RSP_DOUT_RST 9'h000
`define RSP_FAULT_RST 1'b0
`define RSP_CHAIN_RST 34'h0_0000_0000

`endif

// ---- common/rsp_pkg.sv ----
package rsp_pkg;
`include "rsp_consts.svh"

    // address and data words as seen at the pins
    typedef logic [`RSP_ADDR_W-1:0] rsp_addr_t;
    typedef logic [`RSP_DATA_W-1:0] rsp_word_t;

    // operating mode picked from current and prior shift control
    typedef enum logic [2:0] {
        RSP_NORMAL = 3'b001,
        RSP_SHIFT = 3'b010,
        RSP_EXIT = 3'b100
    } rsp_mode_t;

    // complete register state of the controller
    typedef struct packed {
        logic prior_shift;
        logic [`RSP_CHAIN_W-1:0] chain;
        rsp_word_t dout;
        logic fault;
    } rsp_state_t;

endpackage

// ---- verilog/rsp_sram_ctrl.sv ----
`timescale 1ns/100ps
// Functional notes
// RQ1 - all inputs sampled on rising clock edge
// RQ2 - normal only when shift low now and before
// RQ3 - read: gate, pick low, strobe high, normal
// RQ4 - read output changes once to addressed word
// RQ5 - deselect read clears data and fault
// RQ6 - good address parity keeps fault low
// RQ7 - sense selects odd/even; bad read flags fault
// RQ8 - write address parity error flags fault only
// RQ9 - write data needs odd parity, else fault
// RQ10 - scan mode from shift history, scanned gate
// RQ11 - shift rising edge enters scan, holds outputs
// RQ12 - shift high: move chain one bit per edge
// RQ13 - exit, gate bit low: shift then execute
// RQ14 - scanned read/deselect updates outputs only
// RQ15 - exit, gate bit high: chain drives outputs
// RQ16 - gate high: no operation at all
// RQ17 - pick high, strobe low: write inhibited
// RQ18 - writes never change data outputs
// RQ19 - normal serial output is last data msb
// RQ20 - 2048 by 9 memory on eleven address bits
module rsp_sram_ctrl #(
    parameter int ADDR_W = `RSP_ADDR_W, // address field width
    parameter int DATA_W = `RSP_DATA_W  // stored word width
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire rsp_pkg::rsp_addr_t addr_i,
    input wire logic addr_par_bit_i,
    input wire rsp_pkg::rsp_word_t data_in_i,
    input wire logic clk_gate_n_i,
    input wire logic chip_pick_n_i,
    input wire logic write_strobe_n_i,
    input wire logic parity_sense_i,
    input wire logic shift_chain_on_i,
    input wire logic chain_in_i,
    output logic [DATA_W-1:0] data_out_o,
    output logic parity_fault_out_o,
    output logic chain_out_o
);
    import rsp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W; // RQ20

    // storage array, kept outside the state struct on purpose
    logic [DATA_W-1:0] mem_q [DEPTH];

    rsp_state_t st_q; // registered state
    rsp_state_t st_d; // next state
    rsp_mode_t mode; // decoded scan/normal mode
    logic [`RSP_CHAIN_W-1:0] shifted; // chain after one shift
    logic wr_en; // memory write this edge
    logic [ADDR_W-1:0] wr_addr; // memory write address
    logic [DATA_W-1:0] wr_data; // memory write word

    // address bits gathered from their scrambled chain positions
    function automatic logic [ADDR_W-1:0] chain_addr(
        input logic [`RSP_CHAIN_W-1:0] c
    );
        logic [ADDR_W-1:0] a;
        a = '0;
        a[0] = c[`RSP_POS_A0];
        a[1] = c[`RSP_POS_A1];
        a[2] = c[`RSP_POS_A2];
        a[3] = c[`RSP_POS_A3];
        a[4] = c[`RSP_POS_A4];
        a[5] = c[`RSP_POS_A5];
        a[6] = c[`RSP_POS_A6];
        a[7] = c[`RSP_POS_A7];
        a[8] = c[`RSP_POS_A8];
        a[9] = c[`RSP_POS_A9];
        a[10] = c[`RSP_POS_A10];
        return a;
    endfunction

    // input register image plus signature, as loaded on normal cycles
    function automatic logic [`RSP_CHAIN_W-1:0] chain_load(
        input logic [ADDR_W-1:0] a,
        input logic apar,
        input logic we_n,
        input logic cs_n,
        input logic cke_n,
        input logic [DATA_W-1:0] d
    );
        logic [`RSP_CHAIN_W-1:0] c;
        c = '0;
        c[`RSP_POS_FLT:`RSP_POS_Q0] = `RSP_SIGNATURE;
        c[`RSP_POS_APAR] = apar;
        c[`RSP_POS_A0] = a[0];
        c[`RSP_POS_A1] = a[1];
        c[`RSP_POS_A2] = a[2];
        c[`RSP_POS_A3] = a[3];
        c[`RSP_POS_A4] = a[4];
        c[`RSP_POS_A5] = a[5];
        c[`RSP_POS_A6] = a[6];
        c[`RSP_POS_A7] = a[7];
        c[`RSP_POS_A8] = a[8];
        c[`RSP_POS_A9] = a[9];
        c[`RSP_POS_A10] = a[10];
        c[`RSP_POS_WE] = we_n;
        c[`RSP_POS_CS] = cs_n;
        c[`RSP_POS_CKE] = cke_n;
        c[`RSP_POS_LAST:`RSP_POS_D0] = d;
        return c;
    endfunction

    // true when address plus parity bit miss the selected sense
    function automatic logic addr_par_bad(
        input logic [ADDR_W-1:0] a,
        input logic apar,
        input logic sense
    );
        logic odd;
        odd = ^{a, apar};
        return sense ? odd : ~odd; // RQ7
    endfunction

    // mode from the shift control history
    always_comb begin
        unique case ({st_q.prior_shift, shift_chain_on_i}) // RQ10
            2'b00: mode = RSP_NORMAL; // RQ2
            2'b01, 2'b11: mode = RSP_SHIFT;
            2'b10: mode = RSP_EXIT;
        endcase
    end

    assign shifted = {st_q.chain[`RSP_CHAIN_W-2:0], chain_in_i};

    // next-state logic: decode one operation per sampled edge
    always_comb begin
        logic cke_n;
        logic cs_n;
        logic we_n;
        logic apar;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic aerr;
        cke_n = clk_gate_n_i;
        cs_n = chip_pick_n_i;
        we_n = write_strobe_n_i;
        apar = addr_par_bit_i;
        a = addr_i;
        d = data_in_i;
        aerr = 1'b0;
        st_d = st_q;
        wr_en = 1'b0;
        st_d.prior_shift = shift_chain_on_i; // RQ1
        if (mode == RSP_EXIT) begin
            // instruction comes from the chain after its last shift
            cke_n = shifted[`RSP_POS_CKE];
            cs_n = shifted[`RSP_POS_CS];
            we_n = shifted[`RSP_POS_WE];
            apar = shifted[`RSP_POS_APAR];
            a = chain_addr(shifted);
            d = shifted[`RSP_POS_LAST:`RSP_POS_D0];
        end
        aerr = addr_par_bad(a, apar, parity_sense_i);
        wr_addr = a;
        wr_data = d;
        unique case (mode)
            RSP_NORMAL: begin
                // reload chain so the serial output tracks data msb
                st_d.chain = chain_load(a, apar, we_n, cs_n, cke_n, d); // RQ19
                if (!cke_n) begin
                    if (!cs_n && we_n) begin
                        st_d.dout = mem_q[a]; // RQ3 RQ4
                        st_d.fault = aerr; // RQ6 RQ7
                    end else if (cs_n && we_n) begin
                        st_d.dout = '0; // RQ5
                        st_d.fault = 1'b0;
                    end else if (!cs_n) begin
                        wr_en = 1'b1;
                        st_d.fault = aerr | ~(^d); // RQ8 RQ9 RQ18
                    end else begin
                        st_d.fault = 1'b0; // RQ17
                    end
                end
                // gate high leaves memory and outputs alone // RQ16
            end
            RSP_SHIFT: begin
                st_d.chain = shifted; // RQ11 RQ12
            end
            RSP_EXIT: begin
                st_d.chain = shifted;
                if (!cke_n) begin
                    // only read and deselect reach the outputs // RQ13
                    if (!cs_n && we_n) begin
                        st_d.dout = mem_q[a]; // RQ14
                        st_d.fault = aerr;
                    end else if (cs_n && we_n) begin
                        st_d.dout = '0; // RQ14
                        st_d.fault = 1'b0;
                    end else if (!cs_n) begin
                        wr_en = 1'b1;
                    end
                end else begin
                    // test vector forced, input instruction ignored
                    st_d.dout = shifted[DATA_W-1:`RSP_POS_Q0]; // RQ15
                    st_d.fault = shifted[`RSP_POS_FLT];
                end
            end
        endcase
    end

    // state register; reset still acts, otherwise clock enable low freezes everything
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            st_q.prior_shift <= 1'b0;
            st_q.chain <= `RSP_CHAIN_RST;
            st_q.dout <= `RSP_DOUT_RST;
            st_q.fault <= `RSP_FAULT_RST;
        end else if (clk_en_i) begin
            st_q <= st_d; // RQ1
        end
    end

    // memory write port; contents are not cleared by reset
    always_ff @(posedge clk_sys_i) begin
        if (rstn_i && clk_en_i && wr_en) begin
            mem_q[wr_addr] <= wr_data; // RQ20
        end
    end

    assign data_out_o = st_q.dout;
    assign parity_fault_out_o = st_q.fault;
    assign chain_out_o = st_q.chain[`RSP_POS_LAST];

    // helper terms for the checks below
    logic chk_nrm; // enabled normal-mode edge
    logic chk_act; // enabled, gate open, normal
    logic [DATA_W-1:0] chk_word; // word at the pin address
    assign chk_nrm = clk_en_i && (mode == RSP_NORMAL);
    assign chk_act = chk_nrm && !clk_gate_n_i;
    assign chk_word = mem_q[addr_i];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    property p_read_data;
        chk_act && !chip_pick_n_i && write_strobe_n_i
            |=> data_out_o == $past(chk_word);
    endproperty
    a_read_data: assert property (p_read_data) // RQ3
        else $error("read did not present addressed word");

    property p_deselect;
        chk_act && chip_pick_n_i && write_strobe_n_i
            |=> data_out_o == '0 && !parity_fault_out_o;
    endproperty
    a_deselect: assert property (p_deselect) // RQ5
        else $error("deselect did not clear outputs");

    property p_read_par;
        chk_act && !chip_pick_n_i && write_strobe_n_i
            |=> parity_fault_out_o == $past(addr_par_bad(addr_i,
                addr_par_bit_i, parity_sense_i));
    endproperty
    a_read_par: assert property (p_read_par) // RQ7
        else $error("read parity flag wrong");

    property p_write_hold;
        chk_act && !chip_pick_n_i && !write_strobe_n_i
            |=> $stable(data_out_o);
    endproperty
    a_write_hold: assert property (p_write_hold) // RQ18
        else $error("write changed data outputs");

    property p_write_dpar;
        chk_act && !chip_pick_n_i && !write_strobe_n_i && !(^data_in_i)
            |=> parity_fault_out_o;
    endproperty
    a_write_dpar: assert property (p_write_dpar) // RQ9
        else $error("even write data not flagged");

    property p_noop;
        chk_nrm && clk_gate_n_i
            |=> $stable(data_out_o) && $stable(parity_fault_out_o);
    endproperty
    a_noop: assert property (p_noop) // RQ16
        else $error("gated cycle changed outputs");

    property p_shift;
        clk_en_i && shift_chain_on_i
            |=> $stable(data_out_o) && $stable(parity_fault_out_o)
                && chain_out_o == $past(st_q.chain[`RSP_POS_LAST-1]);
    endproperty
    a_shift: assert property (p_shift) // RQ12
        else $error("scan shift misbehaved");

    property p_msb_out;
        chk_nrm |=> chain_out_o == $past(data_in_i[DATA_W-1]);
    endproperty
    a_msb_out: assert property (p_msb_out) // RQ19
        else $error("serial output not last data msb");

    property p_force;
        clk_en_i && mode == RSP_EXIT && shifted[`RSP_POS_CKE]
            |=> data_out_o == $past(shifted[DATA_W-1:0])
                && parity_fault_out_o == $past(shifted[`RSP_POS_FLT]);
    endproperty
    a_force: assert property (p_force) // RQ15
        else $error("forced vector not loaded");

    c_read_err: cover property (chk_act && !chip_pick_n_i
        && write_strobe_n_i ##1 parity_fault_out_o);
    c_write: cover property (chk_act && !chip_pick_n_i
        && !write_strobe_n_i);
    c_scan_exec: cover property (clk_en_i && mode == RSP_EXIT
        && !shifted[`RSP_POS_CKE]);
    c_scan_force: cover property (clk_en_i && mode == RSP_EXIT
        && shifted[`RSP_POS_CKE]);
endmodule

// ---- dv/rsp_scan_host.sv ----
`timescale 1ns/100ps
// scan diagnostics host: shifts one full chain in and records the
// chain that falls out; it owns the shift control and serial input
module rsp_scan_host (
    input wire logic clk_i,
    input wire logic chain_out_i,
    output logic shift_chain_on_o,
    output logic chain_in_o,
    output logic [33:0] captured_o
);
    // shift control low at power up keeps the device in normal mode
    initial begin
        shift_chain_on_o = 1'b0;
        chain_in_o = 1'b0;
        captured_o = 34'h0_0000_0000;
    end
    // call just after a rising edge; 33 shifting edges, then the exit
    // edge, so the whole chain is replaced and read out once
    task automatic scan(input logic [33:0] vec);
        for (int i = 33; i >= 0; i--) begin
            shift_chain_on_o = (i != 0);
            chain_in_o = vec[i];
            // sample before the edge moves the chain
            captured_o = {captured_o[32:0], chain_out_i};
            @(posedge clk_i);
            #1;
        end
        // serial input left as is: normal mode ignores it, and a scan
        // called straight after must not see it set twice in one step
    endtask
endmodule

// ---- dv/tb_registered_sram_parity_scan_ctrl.sv ----
`timescale 1ns/100ps
// compare helper: counts every check and reports a mismatch at once
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_registered_sram_parity_scan_ctrl;
    import rsp_pkg::*;
    // one ordinary cycle: {gate_n, pick_n, strobe_n, sense}, then results
    typedef struct packed {
        logic [3:0] ctl;
        rsp_addr_t a;
        logic apar;
        rsp_word_t d;
        rsp_word_t q;
        logic f;
    } rsp_row_t;
    logic clk_sys_i, rstn_i, clk_en_i, addr_par_bit_i, clk_gate_n_i;
    logic chip_pick_n_i, write_strobe_n_i, parity_sense_i;
    logic shift_chain_on_i, chain_in_i, parity_fault_out_o, chain_out_o;
    rsp_addr_t addr_i;
    rsp_word_t data_in_i;
    logic [8:0] data_out_o;
    logic [33:0] cap; // chain as read out by the host
    int n_mismatch = 0;
    int check_count = 0;
    // rows run back to back; memory starts unwritten after reset
    rsp_row_t rows [11] = '{
        '{4'h0, 11'h005, 1'h1, 9'h001, 9'h000, 1'h0},
        '{4'h0, 11'h00a, 1'h1, 9'h003, 9'h000, 1'h1},
        '{4'h2, 11'h005, 1'h1, 9'h000, 9'h001, 1'h0},
        '{4'h3, 11'h005, 1'h0, 9'h100, 9'h001, 1'h0},
        '{4'h2, 11'h005, 1'h0, 9'h000, 9'h001, 1'h1},
        '{4'h1, 11'h005, 1'h1, 9'h1ff, 9'h001, 1'h1},
        '{4'ha, 11'h00a, 1'h1, 9'h100, 9'h001, 1'h1},
        '{4'h3, 11'h00a, 1'h1, 9'h000, 9'h003, 1'h1},
        '{4'h4, 11'h005, 1'h1, 9'h000, 9'h003, 1'h0},
        '{4'h6, 11'h005, 1'h1, 9'h000, 9'h000, 1'h0},
        '{4'h2, 11'h005, 1'h1, 9'h000, 9'h1ff, 1'h0}
    };

    rsp_sram_ctrl u_dut (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .addr_i(addr_i),
        .addr_par_bit_i(addr_par_bit_i),
        .data_in_i(data_in_i),
        .clk_gate_n_i(clk_gate_n_i),
        .chip_pick_n_i(chip_pick_n_i),
        .write_strobe_n_i(write_strobe_n_i),
        .parity_sense_i(parity_sense_i),
        .shift_chain_on_i(shift_chain_on_i),
        .chain_in_i(chain_in_i),
        .data_out_o(data_out_o),
        .parity_fault_out_o(parity_fault_out_o),
        .chain_out_o(chain_out_o)
    );

    rsp_scan_host u_host (
        .clk_i(clk_sys_i),
        .chain_out_i(chain_out_o),
        .shift_chain_on_o(shift_chain_on_i),
        .chain_in_o(chain_in_i),
        .captured_o(cap)
    );

    // 125 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // verdict in one place for the main flow and the watchdog
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // parallel inputs of one cycle
    task automatic drive(input logic [3:0] c, input rsp_addr_t a,
                         input logic apar, input rsp_word_t d);
        {clk_gate_n_i, chip_pick_n_i, write_strobe_n_i, parity_sense_i} = c;
        addr_i = a;
        addr_par_bit_i = apar;
        data_in_i = d;
    endtask

    // let one edge land, then sit just past it
    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask

    // chain image from an instruction; address bits sit out of order
    function automatic logic [33:0] mk(input logic [2:0] c,
            input rsp_addr_t a, input logic qe, input rsp_word_t q,
            input rsp_word_t d);
        return {d, c, a[7], a[8], a[9], a[10], a[3], a[4], a[5], a[6],
                a[0], a[1], a[2], 1'b0, qe, q};
    endfunction

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_mismatch++;
        conclude();
    end

    initial begin
        clk_en_i = 1'b1;
        rstn_i = 1'b0;
        drive(4'h8, 11'h000, 1'h0, 9'h000);
        repeat (5) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        `CHK({data_out_o, parity_fault_out_o, chain_out_o}, 11'h000);
        for (int i = 0; i < 11; i++) begin
            drive(rows[i].ctl, rows[i].a, rows[i].apar, rows[i].d);
            step();
            `CHK(data_out_o, rows[i].q);
            `CHK(parity_fault_out_o, rows[i].f);
            `CHK(chain_out_o, rows[i].d[8]);
        end
        // enable low: the deselect must not land
        clk_en_i = 1'b0;
        drive(4'h6, 11'h005, 1'h1, 9'h000);
        step();
        `CHK(data_out_o, 9'h1ff);
        clk_en_i = 1'b1;
        drive(4'h2, 11'h00a, 1'h1, 9'h155);
        step();
        // scan with gate bit high; outputs frozen while shifting
        fork
            u_host.scan(mk(3'h4, 11'h000, 1'h1, 9'h0a5, 9'h000));
            begin
                repeat (10) @(posedge clk_sys_i);
                #1;
                `CHK({data_out_o, parity_fault_out_o}, 10'h006);
            end
        join
        `CHK(cap[9:0], 10'h1a9);
        `CHK(cap[33:22], 12'haa9);
        `CHK({data_out_o, parity_fault_out_o}, 10'h14b);
        // scanned write: outputs untouched, output fields ignored
        u_host.scan(mk(3'h0, 11'h481, 1'h1, 9'h0ff, 9'h155));
        `CHK({data_out_o, parity_fault_out_o}, 10'h14b);
        u_host.scan(mk(3'h1, 11'h481, 1'h1, 9'h0ff, 9'h000));
        `CHK({data_out_o, parity_fault_out_o}, 10'h2aa);
        u_host.scan(mk(3'h3, 11'h481, 1'h1, 9'h0ff, 9'h000));
        `CHK({data_out_o, parity_fault_out_o}, 10'h000);
        // first low edge after exit is a normal read again
        drive(4'h2, 11'h481, 1'h0, 9'h000);
        step();
        `CHK(data_out_o, 9'h155);
        // reset in mid-run clears outputs and chain
        rstn_i = 1'b0;
        step();
        rstn_i = 1'b1;
        `CHK({data_out_o, parity_fault_out_o, chain_out_o}, 11'h000);
        conclude();
    end
endmodule
